// ==== hmvip_tx_pkg.sv ====
package hmvip_tx_pkg;
  localparam int AXI_ADDR_W = 12;
  localparam int AXI_DATA_W = 32;
  localparam int REG_IDX_W = 10;
  localparam int IDX_LSB = 2;
  localparam int QUADS = 4;
  localparam int QUAD_W = 2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Register indices; the byte address is four times the index.
  localparam logic [9:0] IDX_COMMON = 10'h001;
  localparam logic [9:0] IDX_STATUS = 10'h002;
  localparam logic [9:0] IDX_QUAD_STRIDE = 10'h100;
  localparam logic [9:0] IDX_QCFG_BASE = 10'h040;
  localparam logic [9:0] IDX_QFP_BASE = 10'h041;
  localparam logic [9:0] IDX_TSOFF_Q1 = 10'h043;
  localparam logic [9:0] IDX_TSOFF_Q2 = 10'h143;
  localparam logic [9:0] IDX_TSOFF_Q3 = 10'h243;
  localparam logic [9:0] IDX_TSOFF_Q4 = 10'h343;

  // Common configuration fields.
  localparam int COM_W = 4;
  localparam int COM_EN_BIT = 0;
  localparam int COM_CCS_EN_BIT = 1;
  localparam int COM_CCS_ORDER_BIT = 2;
  localparam int COM_LINE_STD_BIT = 3;
  localparam logic [3:0] COM_RESET = 4'h0;

  // Per-quadrant backplane configuration fields.
  localparam int QCFG_W = 7;
  localparam int QCFG_CLK_SLAVE_BIT = 0;
  localparam int QCFG_DATA_EDGE_BIT = 1;
  localparam int QCFG_FRAME_EDGE_BIT = 2;
  localparam int QCFG_DOUBLE_CLK_BIT = 3;
  localparam int QCFG_RATE_LSB = 4;
  localparam int QCFG_PARITY_BIT = 6;
  localparam logic [6:0] QCFG_MODE_MASK = 7'h3F;
  localparam logic [6:0] QCFG_HMVIP = 7'h3F;
  localparam logic [6:0] QCFG_RESET = 7'h00;

  // Per-quadrant frame pulse configuration fields.
  localparam int QFP_W = 3;
  localparam int QFP_INVERT_BIT = 0;
  localparam int QFP_KIND_BIT = 1;
  localparam int QFP_DIR_BIT = 2;
  localparam logic [2:0] QFP_HMVIP = 3'h4;
  localparam logic [2:0] QFP_RESET = 3'h0;

  localparam int TSOFF_W = 7;
  localparam logic [6:0] TSOFF_RESET = 7'h00;

  // Status fields.
  localparam int ERR_W = 8;
  localparam int STAT_ERR_LSB = 0;
  localparam int STAT_ALIGNED_BIT = 8;
  localparam int STAT_COUNT_LSB = 16;
  localparam int FRAME_CNT_W = 16;

  // One 125 us frame at 8.192 Mbit/s holds 1024 bits.
  localparam int BIT_CNT_W = 10;
  localparam int SLOT_W = 7;
  localparam int BIT_POS_W = 3;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam int CHAN_W = 5;
  localparam logic [5:0] CHAN_LIMIT_T1 = 6'h18;
  localparam logic [5:0] CHAN_LIMIT_E1 = 6'h20;

  typedef struct packed {
    logic clk8;
    logic fpc;
    logic fp_n;
    logic data;
    logic sig;
    logic ccs;
  } link_pins_t;
  localparam int LINK_W = 6;
  localparam logic [5:0] LINK_RESET = 6'h08;

  typedef struct packed {
    logic [1:0] quadrant;
    logic [4:0] channel;
    logic [7:0] data;
    logic [7:0] signaling;
    logic [7:0] common;
  } tx_octet_t;

  typedef enum logic [1:0] {
    LINK_HUNT = 2'b01,
    LINK_ALIGNED = 2'b10
  } link_state_t;
endpackage

// ==== pin_sampler.sv ====
module pin_sampler #(
  parameter int W = 1,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] raw,
  output logic [W-1:0] clean
);
  logic [W-1:0] ff1, ff2, ff3;
  logic [W-1:0] next_clean;

  // A bit changes only once the second and third stages agree.
  always_comb begin
    next_clean = clean;
    for (int i = 0; i < W; i++) begin
      if (ff2[i] == ff3[i]) begin
        next_clean[i] = ff3[i];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ff1 <= RESET_VAL;
      ff2 <= RESET_VAL;
      ff3 <= RESET_VAL;
      clean <= RESET_VAL;
    end else begin
      ff1 <= raw;
      ff2 <= ff1;
      ff3 <= ff2;
      clean <= next_clean;
    end
  end
endmodule

// ==== hmvip_tx_slave.sv ====
// Behaviour
// - A low frame pulse seen at a frame pulse clock fall starts the next frame.
// - Stream bits are captured on the 8M clock rise at three quarters of a bit.
// - Octets travel most significant bit first, bit one to bit eight.
// - No octet is delivered unless the bus slave enable bit is one.
// - A quadrant works only with the clock slave, both edges, double clock, rate 11.
// - A quadrant works only with non-inverted, per-frame, input frame pulse.
// - Each quadrant owns the timeslots set apart by its own timeslot offset.
// - With parity on, each quadrant frame carries parity checked on data and signaling.
// - Common signaling is passed only when enabled, its bit order set by a control bit.
// - The line standard bit selects T1 channel format at zero and E1 at one.
// - The double clock makes each data bit last two 8M clock periods.
// - With both edge selects at one, data are taken on 8M clock rises and the frame pulse on frame pulse clock falls.
module hmvip_tx_slave
  import hmvip_tx_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [AXI_DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [AXI_DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic shared_8m_bus_clock,
  input wire logic frame_pulse_clock,
  input wire logic frame_pulse_n,
  input wire logic tx_channel_data_stream,
  input wire logic tx_channel_signaling_stream,
  input wire logic tx_common_signaling_stream,
  output tx_octet_t octet,
  output logic octet_valid,
  output logic frame_start
);
  link_pins_t pins;
  logic aw_got, w_got, next_aw_got, next_w_got;
  logic [AXI_ADDR_W-1:0] awaddr_q, next_awaddr_q;
  logic [AXI_DATA_W-1:0] wdata_q, next_wdata_q;
  logic wstrb_q, next_wstrb_q;
  logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [AXI_DATA_W-1:0] next_rdata;
  logic [COM_W-1:0] com, next_com;
  logic [QUADS-1:0][QCFG_W-1:0] qcfg, next_qcfg;
  logic [QUADS-1:0][QFP_W-1:0] qfp, next_qfp;
  logic [QUADS-1:0][TSOFF_W-1:0] tsoff, next_tsoff;
  logic [ERR_W-1:0] err_clr, parity_err, next_err;
  logic [QUADS-1:0] active, active_prev;
  logic com_en, ccs_en, ccs_order, line_std;
  link_state_t state, next_state;
  logic prev_clk8, prev_fpc, rise8, fpc_fall, frame_mark;
  logic phase, next_phase;
  logic [BIT_CNT_W-1:0] bitcnt, next_bitcnt;
  logic [SLOT_W-1:0] slot, ts_prev;
  logic [BIT_POS_W-1:0] bit_pos;
  logic [7:0] sh_data, sh_sig, sh_ccs, next_sh_data, next_sh_sig, next_sh_ccs;
  logic [QUADS-1:0] par_data, par_sig, next_par_data, next_par_sig;
  logic [FRAME_CNT_W-1:0] frame_cnt, next_frame_cnt;
  tx_octet_t next_octet;
  logic next_octet_valid, next_frame_start;
  logic owner_hit, chan_ok;
  logic [QUAD_W-1:0] owner_q;
  logic [CHAN_W-1:0] owner_chan;

  function automatic logic [9:0] quad_idx(input logic [9:0] base,
                                          input int q);
    return 10'(base + IDX_QUAD_STRIDE * q);
  endfunction

  function automatic logic [9:0] tsoff_idx(input int q);
    case (q)
      0: return IDX_TSOFF_Q1;
      1: return IDX_TSOFF_Q2;
      2: return IDX_TSOFF_Q3;
      default: return IDX_TSOFF_Q4;
    endcase
  endfunction

  function automatic logic [7:0] bit_reverse(input logic [7:0] b);
    logic [7:0] r;
    r = '0;
    for (int i = 0; i < 8; i++) begin
      r[i] = b[7-i];
    end
    return r;
  endfunction

  pin_sampler #(.W(LINK_W), .RESET_VAL(LINK_RESET)) u_sampler (
    .aclk(aclk),
    .aresetn(aresetn),
    .raw({shared_8m_bus_clock, frame_pulse_clock, frame_pulse_n,
          tx_channel_data_stream, tx_channel_signaling_stream,
          tx_common_signaling_stream}),
    .clean(pins)
  );

  assign com_en = com[COM_EN_BIT];
  assign ccs_en = com[COM_CCS_EN_BIT];
  assign ccs_order = com[COM_CCS_ORDER_BIT];
  assign line_std = com[COM_LINE_STD_BIT];
  assign slot = bitcnt[BIT_CNT_W-1 -: SLOT_W];
  assign bit_pos = bitcnt[BIT_POS_W-1:0];
  assign rise8 = pins.clk8 & ~prev_clk8;
  assign fpc_fall = ~pins.fpc & prev_fpc;
  assign frame_mark = fpc_fall & ~pins.fp_n;

  // A quadrant runs only when its configuration, parity bit aside, is the H-MVIP one.
  always_comb begin
    for (int q = 0; q < QUADS; q++) begin
      active[q] = com_en
        && ((qcfg[q] & QCFG_MODE_MASK) == QCFG_HMVIP)
        && (qfp[q] == QFP_HMVIP);
    end
  end

  always_comb begin
    logic have_aw, have_w, commit, hit;
    logic [AXI_ADDR_W-1:0] waddr;
    logic [AXI_DATA_W-1:0] wdata;
    logic [REG_IDX_W-1:0] widx, ridx;
    have_aw = aw_got | (s_axi_awvalid & s_axi_awready);
    have_w = w_got | (s_axi_wvalid & s_axi_wready);
    commit = have_aw & have_w;
    waddr = aw_got ? awaddr_q : s_axi_awaddr;
    wdata = w_got ? wdata_q : s_axi_wdata;
    widx = waddr[AXI_ADDR_W-1:IDX_LSB];
    ridx = s_axi_araddr[AXI_ADDR_W-1:IDX_LSB];
    hit = 1'b0;
    next_aw_got = have_aw;
    next_w_got = have_w;
    next_awaddr_q = waddr;
    next_wdata_q = wdata;
    next_wstrb_q = w_got ? wstrb_q : s_axi_wstrb[0];
    next_bvalid = s_axi_bvalid & ~s_axi_bready;
    next_bresp = s_axi_bresp;
    next_rvalid = s_axi_rvalid & ~s_axi_rready;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    next_com = com;
    next_qcfg = qcfg;
    next_qfp = qfp;
    next_tsoff = tsoff;
    err_clr = '0;
    if (commit) begin
      next_aw_got = 1'b0;
      next_w_got = 1'b0;
      next_bvalid = 1'b1;
      // Only the low byte lane carries register bits.
      if (widx == IDX_COMMON) begin
        hit = 1'b1;
        if (next_wstrb_q) next_com = wdata[COM_W-1:0];
      end
      if (widx == IDX_STATUS) begin
        hit = 1'b1;
        if (next_wstrb_q) err_clr = wdata[STAT_ERR_LSB +: ERR_W];
      end
      for (int q = 0; q < QUADS; q++) begin
        if (widx == quad_idx(IDX_QCFG_BASE, q)) begin
          hit = 1'b1;
          if (next_wstrb_q) next_qcfg[q] = wdata[QCFG_W-1:0];
        end
        if (widx == quad_idx(IDX_QFP_BASE, q)) begin
          hit = 1'b1;
          if (next_wstrb_q) next_qfp[q] = wdata[QFP_W-1:0];
        end
        if (widx == tsoff_idx(q)) begin
          hit = 1'b1;
          if (next_wstrb_q) next_tsoff[q] = wdata[TSOFF_W-1:0];
        end
      end
      next_bresp = hit ? RESP_OKAY : RESP_SLVERR;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rdata = '0;
      next_rresp = RESP_SLVERR;
      if (ridx == IDX_COMMON) begin
        next_rdata[COM_W-1:0] = com;
        next_rresp = RESP_OKAY;
      end
      if (ridx == IDX_STATUS) begin
        next_rdata[STAT_ERR_LSB +: ERR_W] = parity_err;
        next_rdata[STAT_ALIGNED_BIT] = (state == LINK_ALIGNED);
        next_rdata[STAT_COUNT_LSB +: FRAME_CNT_W] = frame_cnt;
        next_rresp = RESP_OKAY;
      end
      for (int q = 0; q < QUADS; q++) begin
        if (ridx == quad_idx(IDX_QCFG_BASE, q)) begin
          next_rdata[QCFG_W-1:0] = qcfg[q];
          next_rresp = RESP_OKAY;
        end
        if (ridx == quad_idx(IDX_QFP_BASE, q)) begin
          next_rdata[QFP_W-1:0] = qfp[q];
          next_rresp = RESP_OKAY;
        end
        if (ridx == tsoff_idx(q)) begin
          next_rdata[TSOFF_W-1:0] = tsoff[q];
          next_rresp = RESP_OKAY;
        end
      end
    end
    next_awready = ~next_aw_got & ~next_bvalid;
    next_wready = ~next_w_got & ~next_bvalid;
    next_arready = ~next_rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
      com <= COM_RESET;
      qcfg <= {QUADS{QCFG_RESET}};
      qfp <= {QUADS{QFP_RESET}};
      tsoff <= {QUADS{TSOFF_RESET}};
    end else begin
      aw_got <= next_aw_got;
      w_got <= next_w_got;
      awaddr_q <= next_awaddr_q;
      wdata_q <= next_wdata_q;
      wstrb_q <= next_wstrb_q;
      s_axi_awready <= next_awready;
      s_axi_wready <= next_wready;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_arready <= next_arready;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
      com <= next_com;
      qcfg <= next_qcfg;
      qfp <= next_qfp;
      tsoff <= next_tsoff;
    end
  end

  // Overlapping offsets are a software fault; the lowest quadrant wins then.
  always_comb begin
    logic [SLOT_W-1:0] diff;
    diff = '0;
    owner_hit = 1'b0;
    owner_q = '0;
    owner_chan = '0;
    for (int q = QUADS - 1; q >= 0; q--) begin
      diff = SLOT_W'(slot - tsoff[q]);
      if (diff[1:0] == 2'b00) begin
        owner_hit = 1'b1;
        owner_q = QUAD_W'(q);
        owner_chan = diff[SLOT_W-1:2];
      end
    end
    chan_ok = {1'b0, owner_chan}
      < (line_std ? CHAN_LIMIT_E1 : CHAN_LIMIT_T1);
  end

  always_comb begin
    logic [7:0] ccs_byte;
    ccs_byte = {sh_ccs[6:0], pins.ccs};
    next_state = state;
    next_phase = phase;
    next_bitcnt = bitcnt;
    next_sh_data = sh_data;
    next_sh_sig = sh_sig;
    next_sh_ccs = sh_ccs;
    next_par_data = par_data;
    next_par_sig = par_sig;
    next_err = parity_err & ~err_clr;
    next_frame_cnt = frame_cnt;
    next_octet = octet;
    next_octet_valid = 1'b0;
    next_frame_start = 1'b0;
    if (frame_mark) begin
      next_state = LINK_ALIGNED;
      next_phase = 1'b0;
      next_bitcnt = '0;
      next_frame_start = 1'b1;
      next_frame_cnt = FRAME_CNT_W'(frame_cnt + 1'b1);
      // A set from the closing frame wins over a clear in the same cycle.
      for (int q = 0; q < QUADS; q++) begin
        if (active[q] && qcfg[q][QCFG_PARITY_BIT]) begin
          if (par_data[q]) next_err[2*q] = 1'b1;
          if (par_sig[q]) next_err[2*q+1] = 1'b1;
        end
      end
      next_par_data = '0;
      next_par_sig = '0;
    end else if (rise8 && state == LINK_ALIGNED) begin
      if (!phase) begin
        next_phase = 1'b1;
      end else begin
        next_phase = 1'b0;
        next_sh_data = {sh_data[6:0], pins.data};
        next_sh_sig = {sh_sig[6:0], pins.sig};
        next_sh_ccs = ccs_byte;
        next_bitcnt = BIT_CNT_W'(bitcnt + 1'b1);
        if (owner_hit) begin
          next_par_data[owner_q] = par_data[owner_q] ^ pins.data;
          next_par_sig[owner_q] = par_sig[owner_q] ^ pins.sig;
          if (bit_pos == LAST_BIT && active[owner_q] && chan_ok) begin
            next_octet_valid = 1'b1;
            next_octet.quadrant = owner_q;
            next_octet.channel = owner_chan;
            next_octet.data = {sh_data[6:0], pins.data};
            next_octet.signaling = {sh_sig[6:0], pins.sig};
            next_octet.common = !ccs_en ? 8'h00 :
              (ccs_order ? ccs_byte : bit_reverse(ccs_byte));
          end
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_clk8 <= 1'b0;
      prev_fpc <= 1'b0;
      state <= LINK_HUNT;
      phase <= 1'b0;
      bitcnt <= '0;
      sh_data <= '0;
      sh_sig <= '0;
      sh_ccs <= '0;
      par_data <= '0;
      par_sig <= '0;
      parity_err <= '0;
      frame_cnt <= '0;
      octet <= '0;
      octet_valid <= 1'b0;
      frame_start <= 1'b0;
      ts_prev <= '0;
      active_prev <= '0;
    end else begin
      prev_clk8 <= pins.clk8;
      prev_fpc <= pins.fpc;
      state <= next_state;
      phase <= next_phase;
      bitcnt <= next_bitcnt;
      sh_data <= next_sh_data;
      sh_sig <= next_sh_sig;
      sh_ccs <= next_sh_ccs;
      par_data <= next_par_data;
      par_sig <= next_par_sig;
      parity_err <= next_err;
      frame_cnt <= next_frame_cnt;
      octet <= next_octet;
      octet_valid <= next_octet_valid;
      frame_start <= next_frame_start;
      ts_prev <= slot;
      active_prev <= active;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence seq_frame_mark;
    fpc_fall && !pins.fp_n;
  endsequence
  sequence seq_bit_sample;
    rise8 && phase && state == LINK_ALIGNED && !frame_mark;
  endsequence

  chk_frame_restart: assert property (
    seq_frame_mark |=> bitcnt == '0 && !phase && frame_start
      && state == LINK_ALIGNED)
    else $error("frame pulse did not restart the frame");
  chk_sample_point: assert property (
    octet_valid |-> $past(rise8) && $past(phase))
    else $error("octet not taken on the late rising edge");
  chk_two_clocks: assert property (
    seq_bit_sample |=> !phase ##0 (bitcnt == $past(bitcnt) + 1'b1))
    else $error("bit did not span two clock periods");
  chk_msb_first: assert property (
    octet_valid |-> octet.data == {$past(sh_data[6:0]), $past(pins.data)})
    else $error("octet not assembled msb first");
  chk_enable_gate: assert property (
    (!com_en)[*2] |-> !octet_valid)
    else $error("octet delivered while disabled");
  chk_mode_gate: assert property (
    octet_valid |-> active_prev[octet.quadrant])
    else $error("octet from a quadrant not in bus mode");
  chk_offset_owner: assert property (
    octet_valid |->
      SLOT_W'(ts_prev - tsoff[octet.quadrant]) == {octet.channel, 2'b00})
    else $error("octet outside its quadrant timeslots");
  chk_parity_flag: assert property (
    seq_frame_mark ##0 (active[0] && qcfg[0][QCFG_PARITY_BIT]
      && par_data[0]) |=> parity_err[0])
    else $error("parity error not flagged");
  chk_ccs_off: assert property (
    octet_valid && !$past(ccs_en) |-> octet.common == 8'h00)
    else $error("common signaling passed while disabled");
  chk_t1_channels: assert property (
    octet_valid && !$past(line_std) |->
      {1'b0, octet.channel} < CHAN_LIMIT_T1)
    else $error("T1 channel beyond range");
  chk_write_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |=> s_axi_bvalid)
    else $error("write not answered next cycle");
endmodule

// ==== hmvip_master_model.sv ====
module hmvip_master_model
  import hmvip_tx_pkg::*;
(
  output link_pins_t pins
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int HALF = 24;

  // Each stream gets its own slot-dependent octet, so swapped streams show.
  function automatic logic [7:0] pat(input int s, input int k);
    case (k)
      0: pat = 8'(s) ^ 8'hA5;
      1: pat = 8'(s * 3);
      default: pat = 8'(s) + 8'h31;
    endcase
  endfunction

  // Idle with both clocks high, so a frame always opens on a falling edge.
  initial begin
    pins = 6'h38;
  end

  task automatic run_frame(input int slots);
    logic [7:0] d, g, c;
    pins.fp_n = 1'b0;
    #HALF;
    for (int b = 0; b < slots * 8; b++) begin
      d = pat(b / 8, 0);
      g = pat(b / 8, 1);
      c = pat(b / 8, 2);
      for (int h = 0; h < 2; h++) begin
        pins.clk8 = 1'b0;
        pins.fpc = ~pins.fpc;
        if (h == 0) begin
          pins.data = d[7 - b % 8];
          pins.sig = g[7 - b % 8];
          pins.ccs = c[7 - b % 8];
        end
        #HALF;
        pins.clk8 = 1'b1;
        pins.fp_n = 1'b1;
        #HALF; // Two clock periods make one bit.
      end
    end
    // Released lines show the inverse of their last bit, never a held value.
    pins.data = ~pins.data;
    pins.sig = ~pins.sig;
    pins.ccs = ~pins.ccs;
    pins.fpc = 1'b1;
  endtask
endmodule

// ==== backplane_tx_hmvip_slave_input_tb.sv ====
module backplane_tx_hmvip_slave_input_tb;
  import hmvip_tx_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] awaddr = '0;
  logic [11:0] araddr = '0;
  logic [31:0] wdata = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, octet_valid, frame_start;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, v;
  link_pins_t pins;
  tx_octet_t octet;
  int err_total = 0, comparisons = 0, n_oct = 0, n_fs = 0, s;
  logic [3:0] exp_act = '0;
  logic exp_e1 = 1'b0, exp_ccs = 1'b0, exp_ord = 1'b0;
  logic [7:0] c, cr;

  always #2.5 aclk = ~aclk;

  hmvip_master_model hmvip_master_model_i (.pins(pins));

  hmvip_tx_slave hmvip_tx_slave_i (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .shared_8m_bus_clock(pins.clk8), .frame_pulse_clock(pins.fpc),
    .frame_pulse_n(pins.fp_n), .tx_channel_data_stream(pins.data),
    .tx_channel_signaling_stream(pins.sig),
    .tx_common_signaling_stream(pins.ccs), .octet(octet),
    .octet_valid(octet_valid), .frame_start(frame_start));

  task automatic chk(input logic ok, input string m);
    comparisons++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask

  task automatic axi_wr(input int i, input logic [31:0] d,
                        output logic [1:0] rs);
    int n = 0;
    @(posedge aclk);
    awaddr <= 12'(i * 4);
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      n++;
    end while (bvalid !== 1'b1 && n < 100);
    rs = bresp;
    bready <= 1'b0;
    chk(n < 100, "write answer missing");
  endtask

  task automatic axi_rd(input int i, output logic [31:0] d,
                        output logic [1:0] rs);
    int n = 0;
    @(posedge aclk);
    araddr <= 12'(i * 4);
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
      n++;
    end while (rvalid !== 1'b1 && n < 100);
    d = rdata;
    rs = rresp;
    rready <= 1'b0;
    chk(n < 100, "read answer missing");
  endtask

  // Every octet is judged against the slot it claims to come from.
  always @(posedge aclk) begin
    if (frame_start === 1'b1) n_fs++;
    if (octet_valid === 1'b1) begin
      s = int'(octet.channel) * 4 + int'(octet.quadrant);
      c = hmvip_master_model_i.pat(s, 2);
      for (int i = 0; i < 8; i++) begin
        cr[i] = c[7 - i];
      end
      n_oct++;
      chk(exp_act[octet.quadrant] === 1'b1, "octet from idle quadrant");
      chk(exp_e1 || octet.channel < 24, "channel beyond T1 frame");
      chk(octet.data === hmvip_master_model_i.pat(s, 0), "data");
      chk(octet.signaling === hmvip_master_model_i.pat(s, 1), "sig");
      chk(octet.common === (!exp_ccs ? 8'h00 : exp_ord ? c : cr),
          "common signaling octet");
    end
  end

  task automatic setup(input logic en, e1, ccs, ord, input logic [6:0] c3,
                       input logic [2:0] f4);
    for (int q = 0; q < 4; q++) begin
      axi_wr(int'(IDX_QCFG_BASE) + 256 * q, 32'(q == 2 ? c3 : QCFG_HMVIP), r);
      axi_wr(int'(IDX_QFP_BASE) + 256 * q, 32'(q == 3 ? f4 : QFP_HMVIP), r);
      axi_wr(int'(IDX_TSOFF_Q1) + 256 * q, 32'(q), r);
    end
    axi_wr(int'(IDX_COMMON), {28'h0, e1, ord, ccs, en}, r);
    exp_act = en ? {f4 == QFP_HMVIP, c3 == QCFG_HMVIP, 2'b11} : 4'h0;
    exp_e1 = e1;
    exp_ccs = ccs;
    exp_ord = ord;
  endtask

  // The settle wait covers pin synchronisers after the last bit.
  task automatic run(input int slots);
    n_oct = 0;
    n_fs = 0;
    hmvip_master_model_i.run_frame(slots);
    repeat (20) @(posedge aclk);
  endtask

  task automatic test_registers;
    axi_rd(int'(IDX_TSOFF_Q1), v, r);
    chk(v === 32'h0 && r === RESP_OKAY, "offset reset value");
    axi_wr(int'(IDX_TSOFF_Q2), 32'h1, r);
    axi_rd(int'(IDX_TSOFF_Q2), v, r);
    chk(v === 32'h1, "offset readback");
    axi_wr(16'h3F, 32'h5, r);
    chk(r === RESP_SLVERR, "unmapped write accepted");
    axi_rd(16'h3F, v, r);
    chk(r === RESP_SLVERR && v === 32'h0, "unmapped read accepted");
    $display("test_registers done");
  endtask

  task automatic test_disabled;
    setup(1'b0, 1'b1, 1'b0, 1'b1, QCFG_HMVIP, QFP_HMVIP);
    run(4);
    chk(n_oct == 0, "octets while bus slave disabled");
    $display("test_disabled done");
  endtask

  task automatic test_e1_partial;
    setup(1'b1, 1'b1, 1'b1, 1'b1, 7'h2F, 3'h5);
    run(8);
    chk(n_oct == 4, "E1 octet count");
    chk(n_fs == 1, "E1 frame start count");
    $display("test_e1_partial done");
  endtask

  task automatic test_t1_full;
    setup(1'b1, 1'b0, 1'b1, 1'b0, QCFG_HMVIP, QFP_HMVIP);
    run(100);
    chk(n_oct == 96, "T1 octet count");
    chk(n_fs == 1, "T1 frame start count");
    $display("test_t1_full done");
  endtask

  // The first frame pulse judges the frame before it, so that flag is
  // cleared and only the first frame's parity, judged at the second pulse, is compared.
  task automatic test_parity;
    logic [31:0] v0;
    logic [7:0] e;
    setup(1'b1, 1'b1, 1'b1, 1'b1, QCFG_HMVIP, QFP_HMVIP);
    axi_wr(int'(IDX_QCFG_BASE),
           32'(QCFG_HMVIP) | (32'h1 << QCFG_PARITY_BIT), r);
    run(8);
    axi_wr(int'(IDX_STATUS), 32'hFF, r);
    axi_rd(int'(IDX_STATUS), v0, r);
    chk(v0[7:0] === 8'h00 && v0[8] === 1'b1, "status after clear");
    run(8);
    axi_rd(int'(IDX_STATUS), v, r);
    e = '0;
    e[0] = ^{hmvip_master_model_i.pat(0, 0), hmvip_master_model_i.pat(4, 0)};
    e[1] = ^{hmvip_master_model_i.pat(0, 1), hmvip_master_model_i.pat(4, 1)};
    chk(v[7:0] === e && r === RESP_OKAY, "parity error flags");
    chk(v[31:16] === v0[31:16] + 16'h1, "frame count step");
    $display("test_parity done");
  endtask

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge aclk);
    err_total++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    print_verdict();
  end

  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    test_registers();
    test_disabled();
    test_e1_partial();
    test_t1_full();
    test_parity();
    print_verdict();
  end
endmodule
